/* rtl/rss_pkg.sv */
// Shared constants and types for the regulator start-up sequencer
package rss_pkg;
	// Timing
	localparam int CLK_MHZ = 40;
	localparam int DELAY_US = 100;
	localparam int DELAY_CYC = DELAY_US * CLK_MHZ;
	localparam int TICK_US = 1;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam int RATE_UV_PER_US = 3250;
	// Reference LSB is 0.25 mV, so one tick adds an exact whole step
	localparam int REF_LSB_UV = 250;
	localparam int STEP_LSB = RATE_UV_PER_US * TICK_US / REF_LSB_UV;
	localparam int REF_W = 14;
	localparam int DLY_W = 12;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TGT = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_REF = 8'h0C;
	// Field positions
	localparam int CTRL_OVR_BIT = 0;
	localparam int TGT_NB_LSB = 16;
	localparam int STAT_MODE_BIT = 8;
	localparam int STAT_PH_LSB = 9;
	localparam int STAT_PG_BIT = 12;
	localparam int STAT_CDRV_BIT = 13;
	localparam int STAT_NDRV_BIT = 14;
	localparam int STAT_BOOT_LSB = 16;
	localparam int REF_NB_LSB = 16;
	// Reset values
	localparam logic CTRL_OVR_RST = 1'b0;
	localparam logic [31:0] TGT_RST = 32'h0000_0000;
	// Active phase counts
	localparam logic [2:0] PH_2 = 3'h2;
	localparam logic [2:0] PH_3 = 3'h3;
	localparam logic [2:0] PH_4 = 3'h4;
	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_WAIT = 6'h02,
		ST_LOAD = 6'h04,
		ST_DELAY = 6'h08,
		ST_RAMP = 6'h10,
		ST_DONE = 6'h20
	} rss_state_t;
endpackage

/* rtl/rss_ramp.sv */
// One rail's stepped reference ramp and pre-biased drive enable
`timescale 1ns/100ps
module rss_ramp #(
	parameter int REF_W = rss_pkg::REF_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	// Sequencer control
	input wire logic clr,
	input wire logic run,
	input wire logic fin,
	input wire logic [REF_W-1:0] target,
	input wire logic [REF_W-1:0] fb_sense,
	// Results
	output logic [REF_W-1:0] ref_q,
	output logic at_tgt_q,
	output logic drv_en_q
);
	localparam int TW = $clog2(rss_pkg::TICK_CYC);
	localparam logic [TW-1:0] TICK_LAST = TW'(rss_pkg::TICK_CYC - 1);
	localparam logic [REF_W-1:0] STEP = REF_W'(rss_pkg::STEP_LSB);

	logic [TW-1:0] tick_q;
	wire tick_done = (tick_q == TICK_LAST);
	wire [REF_W-1:0] gap = target - ref_q;
	// Last step is clipped so the reference lands exactly on target
	wire [REF_W-1:0] ref_step = (gap <= STEP) ? target : ref_q + STEP;
	wire [REF_W-1:0] ref_d = (run && tick_done && ref_q < target) ? ref_step : ref_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tick_q <= '0;
			ref_q <= '0;
			at_tgt_q <= 1'b0;
			drv_en_q <= 1'b0;
		end else if (ce) begin
			if (clr) begin
				tick_q <= '0;
				ref_q <= '0;
				at_tgt_q <= 1'b0;
				drv_en_q <= 1'b0;
			end else begin
				tick_q <= (run && !tick_done) ? tick_q + 1'b1 : '0;
				ref_q <= ref_d;
				at_tgt_q <= run && (ref_d == target);
				// Drives stay off while the output sits above the ramp
				if ((run && ref_q > fb_sense) || fin) begin
					drv_en_q <= 1'b1;
				end
			end
		end
	end
endmodule // rss_ramp

/* rtl/rss_seq.sv */
// Start-up sequencer top: prerequisites, mode and phase capture, soft-start, AHB-Lite registers
`timescale 1ns/100ps
// Notes on behaviour
// - Soft-start begins only with all supply flags and enable satisfied.
// - Nothing else is evaluated until the bias supply reset flag is good.
// - Both driver supply reset flags must be good before operation starts.
// - Stay in shutdown while the enable comparator reads low.
// - Enable rising edge latches serial or parallel mode from mode_select_pin.
// - Phase straps are sampled before soft-start to fix core phase count.
// - Only phase4_detect high selects three-phase operation.
// - Both phase straps high select two-phase operation.
// - Serial mode ramps both rails; parallel mode disables the northbridge rail.
// - Serial mode samples the three boot inputs at enable to pick targets.
// - Captured targets hold until enable falls or bias reset occurs.
// - Soft-start starts both references from zero, not from the active targets.
// - A fixed 100 us delay precedes any output rise.
// - References then ramp at 3.25 mV per us toward the targets.
// - Power good is raised when the ramp reaches the final target.
// - Drives stay off while feedback exceeds the ramping reference.
// - Drives enable once the ramping reference passes feedback.
// - Drives enable at the end of soft-start even if feedback stays high.
// - Pre-biased handling applies separately to each rail.
module rss_seq #(
	parameter int REF_W = rss_pkg::REF_W,
	// Target decoding, 0.25 mV units
	parameter logic [13:0] PVI_BASE = 14'h1838,
	parameter logic [13:0] PVI_STEP = 14'h0064,
	parameter logic [13:0] BOOT_BASE = 14'h1838,
	parameter logic [13:0] BOOT_STEP = 14'h0190
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	// Supply and enable status
	input wire logic bias_por_ok,
	input wire logic core_driver_supply,
	input wire logic aux_driver_supply,
	input wire logic en_cmp,
	// Straps and voltage-ID inputs
	input wire logic mode_select_pin,
	input wire logic phase3_detect,
	input wire logic phase4_detect,
	input wire logic [5:0] parallel_voltage_id,
	input wire logic fixed_voltage_enable_in,
	input wire logic serial_vid_data_in,
	input wire logic serial_vid_clock_in,
	// Digitised feedback
	input wire logic [REF_W-1:0] core_fb_sense,
	input wire logic [REF_W-1:0] nb_fb_sense,
	// Regulator control
	output logic [REF_W-1:0] core_ref,
	output logic [REF_W-1:0] nb_ref,
	output logic core_drive_en,
	output logic nb_drive_en,
	output logic nb_enable,
	output logic mode_serial,
	output logic [2:0] phase_count,
	output logic power_good_out,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);
	function automatic logic [REF_W-1:0] dec(input logic [13:0] base, input logic [13:0] step,
		input logic [5:0] code);
		dec = REF_W'(base - 14'(step * code));
	endfunction

	rss_pkg::rss_state_t st_q, st_d;
	logic en_q;
	logic mode_serial_q;
	logic [2:0] phase_q;
	logic [2:0] boot_q;
	logic [REF_W-1:0] core_tgt_q, nb_tgt_q;
	logic [rss_pkg::DLY_W-1:0] dly_q;
	logic pg_q;
	logic ovr_q;
	logic [31:0] tgt_reg_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_q;
	logic rdy_q;
	logic [REF_W-1:0] c_ref, n_ref;
	logic c_at, n_at, c_drv, n_drv;

	// Prerequisite chain: bias first, then driver flags and enable
	wire drv_ok = core_driver_supply && aux_driver_supply;
	wire run_ok = bias_por_ok && drv_ok && en_cmp;
	wire en_rise = bias_por_ok && en_cmp && !en_q;
	wire [2:0] boot_code = {fixed_voltage_enable_in, serial_vid_data_in, serial_vid_clock_in};
	wire [2:0] phase_d = (phase3_detect && phase4_detect) ? rss_pkg::PH_2 :
		(phase4_detect ? rss_pkg::PH_3 : rss_pkg::PH_4);
	// Serial targets come from boot decode unless software overrides them
	wire [REF_W-1:0] sv_core = ovr_q ? tgt_reg_q[REF_W-1:0] :
		dec(BOOT_BASE, BOOT_STEP, {3'h0, boot_code});
	wire [REF_W-1:0] sv_nb = ovr_q ? tgt_reg_q[rss_pkg::TGT_NB_LSB +: REF_W] : sv_core;
	wire [REF_W-1:0] pv_core = dec(PVI_BASE, PVI_STEP, parallel_voltage_id);
	wire mode_d = en_rise ? mode_select_pin : mode_serial_q;
	wire dly_last = (dly_q == rss_pkg::DLY_W'(rss_pkg::DELAY_CYC - 1));
	wire ramp_done = c_at && (n_at || !mode_serial_q);
	wire in_ramp = (st_q == rss_pkg::ST_RAMP);
	wire in_done = (st_q == rss_pkg::ST_DONE);
	wire clr = (st_q == rss_pkg::ST_OFF) || (st_q == rss_pkg::ST_WAIT);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			rss_pkg::ST_OFF: if (run_ok) begin
				st_d = rss_pkg::ST_WAIT;
			end
			rss_pkg::ST_WAIT: st_d = rss_pkg::ST_LOAD;
			rss_pkg::ST_LOAD: st_d = rss_pkg::ST_DELAY;
			rss_pkg::ST_DELAY: if (dly_last) begin
				st_d = rss_pkg::ST_RAMP;
			end
			rss_pkg::ST_RAMP: if (ramp_done) begin
				st_d = rss_pkg::ST_DONE;
			end
			rss_pkg::ST_DONE: st_d = rss_pkg::ST_DONE;
			default: st_d = rss_pkg::ST_OFF;
		endcase
		// Losing any prerequisite drops straight back to shutdown
		if (!run_ok) begin
			st_d = rss_pkg::ST_OFF;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= rss_pkg::ST_OFF;
			en_q <= 1'b0;
			mode_serial_q <= 1'b0;
			phase_q <= rss_pkg::PH_4;
			boot_q <= 3'h0;
			core_tgt_q <= '0;
			nb_tgt_q <= '0;
			dly_q <= '0;
			pg_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			en_q <= bias_por_ok && en_cmp;
			mode_serial_q <= mode_d;
			pg_q <= in_done;
			dly_q <= (st_q == rss_pkg::ST_DELAY) ? dly_q + 1'b1 : '0;
			if (st_q == rss_pkg::ST_WAIT) begin
				phase_q <= phase_d;
			end
			// Targets are taken once per enable and then held
			if (!bias_por_ok || !en_cmp) begin
				core_tgt_q <= '0;
				nb_tgt_q <= '0;
			end else if (en_rise) begin
				boot_q <= boot_code;
				core_tgt_q <= mode_d ? sv_core : pv_core;
				nb_tgt_q <= mode_d ? sv_nb : '0;
			end
		end
	end

	// One ramp per rail keeps the pre-biased handling independent
	rss_ramp #(.REF_W(REF_W)) u_core (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.clr(clr),
		.run(in_ramp),
		.fin(in_done),
		.target(core_tgt_q),
		.fb_sense(core_fb_sense),
		.ref_q(c_ref),
		.at_tgt_q(c_at),
		.drv_en_q(c_drv)
	);
	rss_ramp #(.REF_W(REF_W)) u_nb (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.clr(clr || !mode_serial_q),
		.run(in_ramp),
		.fin(in_done),
		.target(nb_tgt_q),
		.fb_sense(nb_fb_sense),
		.ref_q(n_ref),
		.at_tgt_q(n_at),
		.drv_en_q(n_drv)
	);

	// AHB-Lite: zero wait states, reads decoded in the address phase
	wire take = hsel && hready && htrans[1];
	wire [7:0] a_ofs = {haddr[7:2], 2'b00};
	wire mapped = (haddr[31:8] == 24'h0);
	wire [31:0] stat_w = {13'h0, boot_q, 1'b0, n_drv, c_drv, pg_q, phase_q, mode_serial_q, 2'h0,
		st_q};
	wire [31:0] ref_w = {2'h0, n_ref, 2'h0, c_ref};
	wire [31:0] rd_mux = !mapped ? 32'h0 :
		(a_ofs == rss_pkg::OFS_CTRL) ? {31'h0, ovr_q} :
		(a_ofs == rss_pkg::OFS_TGT) ? tgt_reg_q :
		(a_ofs == rss_pkg::OFS_STAT) ? stat_w :
		(a_ofs == rss_pkg::OFS_REF) ? ref_w : 32'h0;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q <= 32'h0;
			rdy_q <= 1'b1;
			ovr_q <= rss_pkg::CTRL_OVR_RST;
			tgt_reg_q <= rss_pkg::TGT_RST;
		end else if (ce) begin
			rdy_q <= 1'b1;
			wr_pend_q <= take && hwrite && mapped;
			wr_addr_q <= a_ofs;
			if (take && !hwrite) begin
				rdata_q <= rd_mux;
			end
			if (wr_pend_q && wr_addr_q == rss_pkg::OFS_CTRL) begin
				ovr_q <= hwdata[rss_pkg::CTRL_OVR_BIT];
			end
			if (wr_pend_q && wr_addr_q == rss_pkg::OFS_TGT) begin
				tgt_reg_q <= hwdata;
			end
		end
	end

	assign core_ref = c_ref;
	assign nb_ref = n_ref;
	assign core_drive_en = c_drv;
	assign nb_drive_en = n_drv;
	assign nb_enable = mode_serial_q;
	assign mode_serial = mode_serial_q;
	assign phase_count = phase_q;
	assign power_good_out = pg_q;
	assign hreadyout = rdy_q;
	assign hrdata = rdata_q;
	assign hresp = 1'b0;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	chk_start_prereq: assert property ((st_q == rss_pkg::ST_LOAD) |-> $past(run_ok))
		else $error("soft-start entered without prerequisites");
	chk_bias_first: assert property ((ce && !bias_por_ok) |=> (st_q == rss_pkg::ST_OFF))
		else $error("left shutdown without bias supply");
	// Power good is a registered copy of the done state, so it trails shutdown by one edge
	chk_driver_por: assert property ((ce && !drv_ok) |=> clr ##1 !power_good_out)
		else $error("running without driver supplies");
	chk_enable_off: assert property ((ce && !en_cmp) |=> clr ##1 (!c_drv && !n_drv))
		else $error("not in shutdown while enable low");
	chk_mode_latch: assert property ((ce && en_rise) |=> mode_serial_q == $past(mode_select_pin))
		else $error("mode not latched on enable rise");
	chk_two_phase: assert property ((ce && st_q == rss_pkg::ST_WAIT && phase3_detect
		&& phase4_detect) |=> phase_q == rss_pkg::PH_2)
		else $error("two-phase strap not applied");
	chk_nb_parallel: assert property ((!mode_serial_q && !clr) |-> (n_ref == '0 && !n_drv))
		else $error("northbridge active in parallel mode");
	chk_target_hold: assert property ((ce && en_q && en_cmp && bias_por_ok)
		|=> $stable(core_tgt_q) && $stable(nb_tgt_q))
		else $error("targets changed while enabled");
	chk_delay_flat: assert property ((st_q == rss_pkg::ST_DELAY) |-> (c_ref == '0 && n_ref == '0))
		else $error("reference rose during start delay");
	chk_ramp_rate: assert property ((ce && in_ramp && $past(ce) && $past(in_ramp))
		|-> (c_ref - $past(c_ref)) <= REF_W'(rss_pkg::STEP_LSB))
		else $error("ramp step too large");
	chk_pgood_at_tgt: assert property (power_good_out |-> (c_ref == core_tgt_q))
		else $error("power good before target reached");
	chk_prebias_hold: assert property ($rose(c_drv) |-> ($past(c_ref) > $past(core_fb_sense)
		|| $past(in_done)))
		else $error("core drive enabled above reference");
	chk_nb_prebias: assert property ($rose(n_drv) |-> ($past(n_ref) > $past(nb_fb_sense)
		|| $past(in_done)))
		else $error("northbridge drive enabled above reference");
	chk_prereq_drop: assert property ((ce && !run_ok) |=> clr)
		else $error("sequence kept running without prerequisites");
	chk_target_clear: assert property ((ce && !en_cmp) |=>
		(core_tgt_q == '0 && nb_tgt_q == '0))
		else $error("targets kept after enable fell");
	// Start-up order and timing
	chk_load_order: assert property ($rose(st_q == rss_pkg::ST_LOAD)
		|-> ($past(st_q) == rss_pkg::ST_WAIT))
		else $error("load entered out of order");
	chk_delay_entry: assert property ($rose(st_q == rss_pkg::ST_DELAY)
		|-> ($past(st_q) == rss_pkg::ST_LOAD))
		else $error("delay entered without load");
	chk_delay_length: assert property (($rose(in_ramp) && $past(ce))
		|-> ($past(dly_q) == rss_pkg::DLY_W'(rss_pkg::DELAY_CYC - 1)))
		else $error("start delay length wrong");
	chk_ramp_to_done: assert property ($rose(in_done) |-> $past(ramp_done))
		else $error("done entered before targets reached");
	chk_pg_after_done: assert property (($past(ce) && power_good_out)
		|-> $past(in_done))
		else $error("power good without completed soft-start");
	chk_done_core_tgt: assert property (in_done |-> (c_ref == core_tgt_q))
		else $error("core reference off target when done");
	chk_done_nb_tgt: assert property ((in_done && mode_serial_q)
		|-> (n_ref == nb_tgt_q))
		else $error("northbridge reference off target when done");
	chk_ref_bounded: assert property ((in_ramp || in_done)
		|-> (c_ref <= core_tgt_q))
		else $error("core reference passed target");
	// Mode, phases, targets, core drive latch and shutdown outputs
	chk_mode_hold: assert property ((ce && !en_rise) |=> $stable(mode_serial_q))
		else $error("mode changed without enable rise");
	chk_three_phase: assert property ((ce && st_q == rss_pkg::ST_WAIT && !phase3_detect
		&& phase4_detect) |=> (phase_q == rss_pkg::PH_3))
		else $error("three-phase strap not applied");
	chk_four_phase: assert property ((ce && st_q == rss_pkg::ST_WAIT && !phase4_detect)
		|=> (phase_q == rss_pkg::PH_4))
		else $error("four-phase default not applied");
	chk_phase_hold: assert property ((ce && st_q != rss_pkg::ST_WAIT)
		|=> $stable(phase_q))
		else $error("phase count changed outside strap sampling");
	chk_nb_tgt_par: assert property (!mode_serial_q |-> (nb_tgt_q == '0))
		else $error("northbridge target set in parallel mode");
	chk_drive_latch: assert property ((ce && c_drv && !clr) |=> c_drv)
		else $error("core drive dropped during soft-start");
	chk_off_refs: assert property (($past(ce) && st_q == rss_pkg::ST_OFF
		&& $past(st_q) == rss_pkg::ST_OFF) |-> (c_ref == '0 && n_ref == '0 && !power_good_out))
		else $error("references or power good active in shutdown");
	// Read data must stand until the next read is taken
	chk_rdata_hold: assert property ((ce && !(take && !hwrite)) |=> $stable(hrdata))
		else $error("read data changed without a read");

	cov_serial_done: cover property (in_done && mode_serial_q);
	cov_parallel_done: cover property (in_done && !mode_serial_q);
	cov_prebias_late: cover property ($rose(c_drv) && $past(in_done));
	cov_three_phase: cover property (phase_q == rss_pkg::PH_3 && in_ramp);
	cov_two_phase: cover property (phase_q == rss_pkg::PH_2 && in_done);
endmodule // rss_seq

/* bench/rss_partner.sv */
// Far-side model: external driver supply flags, enable sequencing and rail feedback
`timescale 1ns/100ps
module rss_partner (
	// Clock and control from the bench
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic power_up,
	input wire logic skip_drv,
	input wire logic [13:0] pre_core,
	input wire logic [13:0] pre_nb,
	// Regulator control from the sequencer
	input wire logic [13:0] core_ref,
	input wire logic [13:0] nb_ref,
	input wire logic core_drive_en,
	input wire logic nb_drive_en,
	// Status and feedback to the sequencer
	output logic core_driver_supply,
	output logic aux_driver_supply,
	output logic en_cmp,
	output logic [13:0] core_fb_sense,
	output logic [13:0] nb_fb_sense
);
	logic [3:0] up_q;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			up_q <= 4'h0;
		end else begin
			up_q <= {up_q[2:0], power_up};
		end
	end
	// Drivers come up three cycles before enable; skip_drv breaks this on purpose
	assign core_driver_supply = up_q[0] & ~skip_drv;
	assign aux_driver_supply = up_q[0] & ~skip_drv;
	assign en_cmp = up_q[3];
	// A rail sits at its pre-charge until switching starts, then follows the reference
	assign core_fb_sense = core_drive_en ? core_ref : pre_core;
	assign nb_fb_sense = nb_drive_en ? nb_ref : pre_nb;
endmodule // rss_partner

/* bench/tb_rss_seq.sv */
// Self-checking bench for the regulator start-up sequencer
`timescale 1ns/100ps
module tb_rss_seq;
	localparam logic [13:0] PB = 14'h1838;
	localparam logic [13:0] PS = 14'h0064;
	localparam logic [13:0] BB = 14'h1838;
	localparam logic [13:0] BS = 14'h0190;
	localparam int LIMIT = 40000;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic bias_por_ok = 1'b0;
	logic mode_select_pin = 1'b0;
	logic phase3_detect = 1'b0;
	logic phase4_detect = 1'b0;
	logic [5:0] parallel_voltage_id = 6'h00;
	logic [2:0] boot = 3'h0;
	logic power_up = 1'b0;
	logic skip_drv = 1'b0;
	logic [13:0] pre_core = 14'h0000;
	logic [13:0] pre_nb = 14'h0000;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic core_driver_supply, aux_driver_supply, en_cmp, core_drive_en, nb_drive_en;
	logic nb_enable, mode_serial, power_good_out, hreadyout, hresp;
	logic [13:0] core_fb_sense, nb_fb_sense, core_ref, nb_ref;
	logic [2:0] phase_count;
	logic [31:0] hrdata;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;

	always #12.5 ref_clk = ~ref_clk;

	rss_seq #(.PVI_BASE(PB), .PVI_STEP(PS), .BOOT_BASE(BB), .BOOT_STEP(BS)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1), .bias_por_ok(bias_por_ok),
		.core_driver_supply(core_driver_supply), .aux_driver_supply(aux_driver_supply),
		.en_cmp(en_cmp), .mode_select_pin(mode_select_pin), .phase3_detect(phase3_detect),
		.phase4_detect(phase4_detect), .parallel_voltage_id(parallel_voltage_id),
		.fixed_voltage_enable_in(boot[2]), .serial_vid_data_in(boot[1]),
		.serial_vid_clock_in(boot[0]), .core_fb_sense(core_fb_sense),
		.nb_fb_sense(nb_fb_sense), .core_ref(core_ref), .nb_ref(nb_ref),
		.core_drive_en(core_drive_en), .nb_drive_en(nb_drive_en), .nb_enable(nb_enable),
		.mode_serial(mode_serial), .phase_count(phase_count),
		.power_good_out(power_good_out), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

	rss_partner far (
		.ref_clk(ref_clk), .rstn(rstn), .power_up(power_up), .skip_drv(skip_drv),
		.pre_core(pre_core), .pre_nb(pre_nb), .core_ref(core_ref), .nb_ref(nb_ref),
		.core_drive_en(core_drive_en), .nb_drive_en(nb_drive_en),
		.core_driver_supply(core_driver_supply), .aux_driver_supply(aux_driver_supply),
		.en_cmp(en_cmp), .core_fb_sense(core_fb_sense), .nb_fb_sense(nb_fb_sense));

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single word transfer; the slave may stretch either phase
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		check(x & m, e);
	endtask

	task automatic run(input logic ser, input logic [1:0] ph, input logic [5:0] code,
		input logic [2:0] bc, input logic [13:0] pc, input logic [13:0] pn,
		input logic [2:0] eph, input logic [13:0] tgt);
		int n;
		int steps;
		logic [13:0] last;
		mode_select_pin <= ser;
		{phase3_detect, phase4_detect} <= ph;
		parallel_voltage_id <= code;
		boot <= bc;
		pre_core <= pc;
		pre_nb <= pn;
		power_up <= 1'b1;
		@(posedge ref_clk);
		while (en_cmp !== 1'b1) @(posedge ref_clk);
		n = 0;
		last = 14'h0;
		steps = (int'(tgt) + 12) / 13;
		while (power_good_out !== 1'b1) begin
			@(posedge ref_clk);
			n++;
			if (n == 20) begin
				parallel_voltage_id <= ~code;
				boot <= ~bc;
			end
			if (n < 4000) check({core_drive_en, core_ref}, 32'h0);
			if (core_ref !== last) check(core_ref == tgt || core_ref == last + 14'd13, 1);
			last = core_ref;
			if (core_ref + 14'd13 < pc) check(core_drive_en, 1'b0);
			if (core_ref > pc + 14'd26) check(core_drive_en, 1'b1);
			// The serial run pre-charges the northbridge rail above its target
			if (!ser || nb_ref < tgt) check(nb_drive_en, 1'b0);
		end
		check(n >= 4000 + (steps - 1) * 40 && n <= 4050 + steps * 40, 1);
		check(core_ref, tgt);
		check(nb_ref, ser ? tgt : 14'h0);
		check({mode_serial, nb_enable, phase_count}, {ser, ser, eph});
		@(posedge ref_clk);
		check({core_drive_en, nb_drive_en}, {1'b1, ser});
		power_up <= 1'b0;
		repeat (8) @(posedge ref_clk);
		check({power_good_out, core_drive_en, core_ref}, 32'h0);
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		check({power_good_out, phase_count, hreadyout, hresp}, 6'b0_100_1_0);
		rd({24'h0, rss_pkg::OFS_TGT}, 32'hFFFF_FFFF, rss_pkg::TGT_RST);
		rd({24'h0, rss_pkg::OFS_CTRL}, 32'hFFFF_FFFF, {31'h0, rss_pkg::CTRL_OVR_RST});
		wr({24'h0, rss_pkg::OFS_TGT}, 32'hFFFF_FFFF);
		rd({24'h0, rss_pkg::OFS_TGT}, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
		wr({24'h0, rss_pkg::OFS_CTRL}, 32'hFFFF_FFFF);
		rd({24'h0, rss_pkg::OFS_CTRL}, 32'hFFFF_FFFF, 32'h1);
		wr({24'h0, rss_pkg::OFS_CTRL}, 32'h0);
		wr(32'h10, 32'hFFFF_FFFF);
		rd(32'h10, 32'hFFFF_FFFF, 32'h0);
		rd(32'h100, 32'hFFFF_FFFF, 32'h0);
		// Enable and drivers up while the bias flag is still low
		power_up <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rd({24'h0, rss_pkg::OFS_STAT}, 32'h3F, 32'h1);
		power_up <= 1'b0;
		bias_por_ok <= 1'b1;
		skip_drv <= 1'b1;
		repeat (6) @(posedge ref_clk);
		power_up <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rd({24'h0, rss_pkg::OFS_STAT}, 32'h3F, 32'h1);
		power_up <= 1'b0;
		skip_drv <= 1'b0;
		repeat (6) @(posedge ref_clk);
		power_up <= 1'b1;
		repeat (100) @(posedge ref_clk);
		rd({24'h0, rss_pkg::OFS_STAT}, 32'hE3F, {20'h0, rss_pkg::PH_4, 9'h008});
		power_up <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rd({24'h0, rss_pkg::OFS_STAT}, 32'h103F, 32'h1);
		run(1'b0, 2'b01, 6'h20, 3'h0, 14'h0, 14'h0, 3'h3, PB - 14'd32 * PS);
		run(1'b1, 2'b11, 6'h00, 3'h3, 14'd1000, 14'h3FFF, 3'h2, BB - 14'd3 * BS);
		report_and_stop();
	end
endmodule // tb_rss_seq
